// *** design/ddcr_top.sv ***
// Configuration slice for two downconverter channels plus the sample
// path that the channel 3 control bits steer. Holds channel 2's phase
// offset word and test enables and channel 3's control register.
// Assumes the configuration port and the sample stream share CLOCK.
//
// Overview of operation
// [R1] Phase offset bits 47:24 live in three zero-reset byte registers.
// [R2] Q test enable bit 2 swaps Q samples for pattern B.
// [R3] I test enable bit 0 swaps I samples for pattern A.
// [R4] Pattern content comes from an outside selector, not these bits.
// [R5] Mixer bit 7: 0 real, 1 complex; software routes inputs.
// [R6] Gain bit 6: 0 unity, 1 doubles samples.
// [R7] IF field bits 5:4: variable, zero hertz, fs/4, or test.
// [R8] Complex-to-real bit 3: real I only via extra fs/4 mixing.
// [R9] Decimation code 000 uses halfband stages one and two.
// [R10] Decimation code 001 uses halfband stages one to three.
// [R11] Decimation code 010 uses all four halfband stages.
// [R12] Phase offset bits 23:0 sit in the three registers below.
// [R13] Reserved test enable bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module ddcr_top
    import ddcr_pkg::*;
(
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic CE,
    // Configuration port
    input wire logic [ddcr_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [ddcr_pkg::DATA_W-1:0] REG_WDATA,
    output logic [ddcr_pkg::DATA_W-1:0] REG_RDATA,
    // Configuration seen by the oscillator and filter chain
    output logic [ddcr_pkg::PO_W-1:0] OSCILLATOR_PHASE_OFFSET_WORD,
    output logic MIXER_COMPLEX,
    output logic [1:0] IF_MODE,
    output logic [ddcr_pkg::HB_STAGES-1:0] HALFBAND_STAGE_EN,
    output logic COMPLEX_TO_REAL,
    // Input samples
    input wire logic [ddcr_pkg::SAMPLE_W-1:0] IN_I,
    input wire logic [ddcr_pkg::SAMPLE_W-1:0] IN_Q,
    input wire logic IN_VALID,
    output logic IN_READY,
    // Test pattern generator outputs
    input wire logic [ddcr_pkg::SAMPLE_W-1:0] PATTERN_A,
    input wire logic [ddcr_pkg::SAMPLE_W-1:0] PATTERN_B,
    // Output samples
    output logic [ddcr_pkg::SAMPLE_W-1:0] OUT_I,
    output logic [ddcr_pkg::SAMPLE_W-1:0] OUT_Q,
    output logic OUT_VALID,
    input wire logic OUT_READY
);
    import ddcr_pkg::*;

    // Register state
    logic [DATA_W-1:0] po_reg [PO_BYTES];
    logic [DATA_W-1:0] test_en_reg;
    logic [DATA_W-1:0] ctrl_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic [HB_STAGES-1:0] hb_en_reg;
    logic [HB_STAGES-1:0] hb_en_next;

    // Sample path state
    logic in_ready_reg;
    logic in_ready_next;
    ddcr_mix_phase_t mix_ph_reg;
    logic [DEC_CNT_W-1:0] dec_cnt_reg;
    logic [DEC_CNT_W-1:0] dec_cnt_next;
    logic st_valid_reg;
    logic [SAMPLE_W-1:0] st_i_reg;
    logic [SAMPLE_W-1:0] st_q_reg;

    // Decoded fields
    wire wr_test_en;
    wire wr_ctrl;
    wire mix_complex;
    wire gain_en;
    wire [1:0] if_field;
    wire c2r_en;
    wire [2:0] dec_code;
    wire test_i_en;
    wire test_q_en;

    // Datapath wires
    wire accept;
    wire keep;
    wire fifo_in_ready;
    wire fifo_push;
    wire [FIFO_CNT_W-1:0] fifo_count;
    wire [DEC_CNT_W-1:0] dec_last;
    wire [SAMPLE_W-1:0] neg_i;
    wire [SAMPLE_W-1:0] neg_q;
    wire [SAMPLE_W-1:0] real_i;
    wire [SAMPLE_W-1:0] pre_i;
    wire [SAMPLE_W-1:0] pre_q;
    wire [SAMPLE_W-1:0] lane_in [2];
    wire [SAMPLE_W-1:0] lane_pat [2];
    wire lane_test [2];
    wire [SAMPLE_W-1:0] lane_out [2];
    wire [FIFO_W-1:0] fifo_out;

    // Negation that clips the most negative code instead of wrapping
    function automatic logic [SAMPLE_W-1:0] neg_sat(
        input logic [SAMPLE_W-1:0] v
    );
        logic [SAMPLE_W-1:0] r;
        r = SAMPLE_W'(-v);
        if (v == {1'b1, {(SAMPLE_W-1){1'b0}}})
        begin
            r = {1'b0, {(SAMPLE_W-1){1'b1}}};
        end
        return r;
    endfunction

    // Read-back selection; unmapped addresses answer zero
    function automatic logic [DATA_W-1:0] read_mux(
        input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] tst,
        input logic [DATA_W-1:0] ctl,
        input logic [PO_W-1:0] po
    );
        logic [DATA_W-1:0] r;
        r = UNMAPPED_BYTE;
        for (int k = 0; k < PO_BYTES; k++)
        begin
            if (a == ADDR_PO_BYTE0 + ADDR_W'(k))
            begin
                r = po[k*DATA_W +: DATA_W];
            end
        end
        if (a == ADDR_TEST_EN)
        begin
            r = tst & TEN_WR_MASK;  // [R13]
        end
        if (a == ADDR_CTRL)
        begin
            r = ctl;
        end
        return r;
    endfunction

    // Field decode of the stored configuration
    // IF mode and mixer only leave here
    assign wr_test_en = REG_WR && (REG_ADDR == ADDR_TEST_EN);
    assign wr_ctrl = REG_WR && (REG_ADDR == ADDR_CTRL);
    assign mix_complex = ctrl_reg[CTRL_MIX_BIT];  // [R5]
    assign gain_en = ctrl_reg[CTRL_GAIN_BIT];  // [R6]
    assign if_field = ctrl_reg[CTRL_IF_MSB:CTRL_IF_LSB];  // [R7]
    assign c2r_en = ctrl_reg[CTRL_C2R_BIT];  // [R8]
    assign dec_code = ctrl_reg[CTRL_DEC_MSB:CTRL_DEC_LSB];
    assign test_i_en = test_en_reg[TEN_I_BIT];  // [R3]
    assign test_q_en = test_en_reg[TEN_Q_BIT];  // [R2]

    // Phase offset bytes, lowest first, in consecutive addresses
    // Not shadowed: bytes change singly
    generate
        for (genvar g = 0; g < PO_BYTES; g++)
        begin : g_po
            wire wr_po;
            assign wr_po = REG_WR && (REG_ADDR == ADDR_PO_BYTE0 + ADDR_W'(g));
            assign OSCILLATOR_PHASE_OFFSET_WORD[g*DATA_W +: DATA_W] =
                po_reg[g];  // [R1] [R12]
            always_ff @(posedge CLOCK or negedge NRST)
            begin
                if (!NRST)
                    po_reg[g] <= RESET_BYTE;
                else if (CE && wr_po)
                    po_reg[g] <= REG_WDATA;  // [R1] [R12]
            end
        end
    endgenerate

    // Test enable and control registers; reserved bits never store
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            test_en_reg <= RESET_BYTE;
            ctrl_reg <= RESET_BYTE;
        end
        else if (CE)
        begin
            if (wr_test_en)
                test_en_reg <= REG_WDATA & TEN_WR_MASK;  // [R13]
            if (wr_ctrl)
                ctrl_reg <= REG_WDATA;
        end
    end

    // Read data is registered so the port sees a clean flop output
    assign rdata_next = REG_RD ? read_mux(REG_ADDR, test_en_reg, ctrl_reg,
                                          OSCILLATOR_PHASE_OFFSET_WORD)
                               : rdata_reg;
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            rdata_reg <= RESET_BYTE;
        end
        else if (CE)
        begin
            rdata_reg <= rdata_next;
        end
    end
    assign REG_RDATA = rdata_reg;

    // Halfband chain from the decimation code; other codes keep stages 1-2
    // Reset equals the code 000 choice
    assign hb_en_next = (dec_code == DEC_HB1234) ? HB_EN_HB1234  // [R11]
                      : (dec_code == DEC_HB123) ? HB_EN_HB123  // [R10]
                      : HB_EN_HB12;  // [R9]
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
            hb_en_reg <= HB_EN_HB12;
        else if (CE)
            hb_en_reg <= hb_en_next;
    end
    assign HALFBAND_STAGE_EN = hb_en_reg;
    assign MIXER_COMPLEX = mix_complex;
    assign IF_MODE = if_field;
    assign COMPLEX_TO_REAL = c2r_en;

    // Decimation ratio: one extra halving per enabled stage beyond two,
    // one less when complex to real runs at the doubled real rate
    // Sixteen wraps to zero; minus one gives 15
    assign dec_last = (DEC_CNT_W'(1) << (DEC_CNT_W'(DEC_LOG2_BASE)
                      + DEC_CNT_W'(hb_en_reg[2]) + DEC_CNT_W'(hb_en_reg[3])
                      - DEC_CNT_W'(c2r_en)))
                      - DEC_CNT_W'(1);  // [R9] [R10] [R11]
    assign accept = CE && IN_VALID && in_ready_reg;
    assign keep = (dec_cnt_reg == '0);
    assign dec_cnt_next = (dec_cnt_reg >= dec_last) ? '0
                        : dec_cnt_reg + DEC_CNT_W'(1);

    // Extra fs/4 mixing: I, -Q, -I, Q repeating at the input rate
    assign neg_i = neg_sat(IN_I);
    assign neg_q = neg_sat(IN_Q);
    assign real_i = (mix_ph_reg == MIX_PH0) ? IN_I
                  : (mix_ph_reg == MIX_PH1) ? neg_q
                  : (mix_ph_reg == MIX_PH2) ? neg_i
                  : IN_Q;
    assign pre_i = c2r_en ? real_i : IN_I;  // [R8]
    assign pre_q = c2r_en ? '0 : IN_Q;  // [R8]

    // Mixer phase and decimation counter advance per accepted sample
    // Dropped samples step the phase too
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            mix_ph_reg <= MIX_PH0;
            dec_cnt_reg <= '0;
        end
        else if (accept)
        begin
            mix_ph_reg <= ddcr_mix_phase_t'(mix_ph_reg + 2'h1);
            dec_cnt_reg <= dec_cnt_next;
        end
    end

    // Lane inputs: I uses pattern A, Q uses pattern B
    assign lane_in[0] = pre_i;
    assign lane_in[1] = pre_q;
    assign lane_pat[0] = PATTERN_A;
    assign lane_pat[1] = PATTERN_B;
    assign lane_test[0] = test_i_en;  // [R3]
    assign lane_test[1] = test_q_en;  // [R2]

    // Gain and test substitution, identical for both lanes
    generate
        for (genvar l = 0; l < 2; l++)
        begin : g_lane
            ddcr_lane u_lane (
                .sample(lane_in[l]),
                .gain_en(gain_en),
                .test_en(lane_test[l]),
                .pattern(lane_pat[l]),
                .result(lane_out[l])
            );
        end
    endgenerate

    // Stage register between the lanes and the FIFO
    // Slack means no kept sample meets a full stage
    assign fifo_push = st_valid_reg && fifo_in_ready;
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            st_valid_reg <= 1'b0;
            st_i_reg <= '0;
            st_q_reg <= '0;
        end
        else if (CE)
        begin
            if (accept && keep)
            begin
                st_valid_reg <= 1'b1;
                st_i_reg <= lane_out[0];
                st_q_reg <= lane_out[1];
            end
            else if (fifo_push)
            begin
                st_valid_reg <= 1'b0;
            end
        end
    end

    // Input ready keeps three words of slack so it can be a flop: the
    // stage and one accepted sample always find room downstream
    // Cost: three FIFO slots sit idle
    assign in_ready_next = (fifo_count < FIFO_CNT_W'(FIFO_DEPTH - 3));
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
            in_ready_reg <= 1'b0;
        else if (CE)
            in_ready_reg <= in_ready_next;
    end
    assign IN_READY = in_ready_reg;

    // Output buffer; a stalled consumer pushes back to IN_READY
    // Freezes with CE like all other state
    ddcr_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH),
        .CNT_W(FIFO_CNT_W)
    ) u_fifo (
        .clk(CLOCK),
        .rst_n(NRST),
        .ce(CE),
        .in_valid(st_valid_reg),
        .in_ready(fifo_in_ready),
        .in_data({st_q_reg, st_i_reg}),
        .out_valid(OUT_VALID),
        .out_ready(OUT_READY),
        .out_data(fifo_out),
        .count(fifo_count)
    );
    assign OUT_I = fifo_out[SAMPLE_W-1:0];
    assign OUT_Q = fifo_out[FIFO_W-1:SAMPLE_W];
endmodule
`default_nettype wire

// *** design/ddcr_pkg.sv ***
// Package for the downconverter configuration slice: register offsets,
// field positions, reset values, mode encodings and datapath sizes.
// Assumes a byte-wide configuration port and 16-bit I/Q samples.
package ddcr_pkg;

    // Widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int SAMPLE_W = 16;
    localparam int FIFO_W = 2 * SAMPLE_W;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_CNT_W = 5;
    localparam int PO_BYTES = 6;
    localparam int PO_W = PO_BYTES * DATA_W;
    localparam int DEC_CNT_W = 4;
    localparam int HB_STAGES = 4;

    // Register offsets (byte addresses on the configuration port)
    localparam logic [ADDR_W-1:0] ADDR_PO_BYTE0 = 12'h35D;
    localparam logic [ADDR_W-1:0] ADDR_PO_BYTE3 = 12'h360;
    localparam logic [ADDR_W-1:0] ADDR_PO_BYTE4 = 12'h361;
    localparam logic [ADDR_W-1:0] ADDR_PO_BYTE5 = 12'h362;
    localparam logic [ADDR_W-1:0] ADDR_TEST_EN = 12'h367;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h370;

    // Reset values and read value of unmapped space
    localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_BYTE = 8'h00;

    // Test enable register fields
    localparam int TEN_I_BIT = 0;
    localparam int TEN_Q_BIT = 2;
    localparam logic [DATA_W-1:0] TEN_WR_MASK = 8'h05;

    // Control register fields
    localparam int CTRL_MIX_BIT = 7;
    localparam int CTRL_GAIN_BIT = 6;
    localparam int CTRL_IF_MSB = 5;
    localparam int CTRL_IF_LSB = 4;
    localparam int CTRL_C2R_BIT = 3;
    localparam int CTRL_DEC_MSB = 2;
    localparam int CTRL_DEC_LSB = 0;

    // Decimation: overall ratio is 2^(DEC_LOG2_BASE + code - c2r) for codes 000 to 010; other codes give 2^(DEC_LOG2_BASE - c2r)
    localparam int DEC_LOG2_BASE = 2;

    typedef enum logic [1:0] {
        IF_VARIABLE = 2'b00,
        IF_ZERO_HZ = 2'b01,
        IF_FS_DIV4 = 2'b10,
        IF_TEST = 2'b11
    } ddcr_if_mode_t;

    typedef enum logic [2:0] {
        DEC_HB12 = 3'b000,
        DEC_HB123 = 3'b001,
        DEC_HB1234 = 3'b010
    } ddcr_dec_t;

    // Halfband stage enables per decimation code, stage 1 in bit 0
    localparam logic [HB_STAGES-1:0] HB_EN_HB12 = 4'h3;
    localparam logic [HB_STAGES-1:0] HB_EN_HB123 = 4'h7;
    localparam logic [HB_STAGES-1:0] HB_EN_HB1234 = 4'hF;

    // Phase of the extra fs/4 mixing used for complex to real
    typedef enum logic [1:0] {
        MIX_PH0 = 2'b00,
        MIX_PH1 = 2'b01,
        MIX_PH2 = 2'b10,
        MIX_PH3 = 2'b11
    } ddcr_mix_phase_t;

endpackage

// *** design/ddcr_fifo.sv ***
// Synchronous FIFO with a registered output word, valid/ready both sides.
// Assumes one clock, a clock enable that freezes it, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ddcr_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int CNT_W = 5
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [CNT_W-1:0] count
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic out_valid_reg;
    logic [WIDTH-1:0] out_data_reg;
    wire push;
    wire pop;

    // Output register refills whenever it is empty or being drained
    assign in_ready = (cnt_reg < CNT_W'(DEPTH));
    assign push = ce && in_valid && in_ready;
    assign pop = ce && (cnt_reg != '0) && (!out_valid_reg || out_ready);
    assign out_valid = out_valid_reg;
    assign out_data = out_data_reg;
    assign count = cnt_reg;

    // Storage array has no reset, so it maps onto plain RAM
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr_reg] <= in_data;
    end

    // Pointers, fill count and the registered read word
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end
        else if (ce)
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
                out_data_reg <= mem[rd_ptr_reg];
                out_valid_reg <= 1'b1;
            end
            else if (out_ready)
                out_valid_reg <= 1'b0;
            cnt_reg <= cnt_reg + CNT_W'(push) - CNT_W'(pop);
        end
    end
endmodule
`default_nettype wire

// *** design/ddcr_lane.sv ***
// One output lane: optional 6 dB gain with saturation, then test-pattern
// substitution. Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module ddcr_lane
    import ddcr_pkg::*;
(
    input wire logic [ddcr_pkg::SAMPLE_W-1:0] sample,
    input wire logic gain_en,
    input wire logic test_en,
    input wire logic [ddcr_pkg::SAMPLE_W-1:0] pattern,
    output logic [ddcr_pkg::SAMPLE_W-1:0] result
);
    wire overflow;
    wire [SAMPLE_W-1:0] sat_value;
    wire [SAMPLE_W-1:0] doubled;
    wire [SAMPLE_W-1:0] gained;

    // Doubling overflows when the two top bits differ; clip, never wrap
    assign overflow = sample[SAMPLE_W-1] ^ sample[SAMPLE_W-2];
    assign sat_value = sample[SAMPLE_W-1] ? {1'b1, {(SAMPLE_W-1){1'b0}}}
                                          : {1'b0, {(SAMPLE_W-1){1'b1}}};
    assign doubled = overflow ? sat_value : {sample[SAMPLE_W-2:0], 1'b0};
    assign gained = gain_en ? doubled : sample;  // [R6]
    // Pattern content is picked outside; this lane only swaps it in
    assign result = test_en ? pattern : gained;  // [R4]
endmodule
`default_nettype wire

// *** test/ddcr_top_checker.sv ***
// Assertion checker for the downconverter configuration slice.
// Sees only the top module's ports; bound into every ddcr_top.
`timescale 1ns/1ps
`default_nettype none
module ddcr_top_checker
    import ddcr_pkg::*;
(
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic CE,
    input wire logic [ddcr_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [ddcr_pkg::DATA_W-1:0] REG_WDATA,
    input wire logic [ddcr_pkg::DATA_W-1:0] REG_RDATA,
    input wire logic [ddcr_pkg::PO_W-1:0] OSCILLATOR_PHASE_OFFSET_WORD,
    input wire logic MIXER_COMPLEX,
    input wire logic [1:0] IF_MODE,
    input wire logic [ddcr_pkg::HB_STAGES-1:0] HALFBAND_STAGE_EN,
    input wire logic COMPLEX_TO_REAL,
    input wire logic [ddcr_pkg::SAMPLE_W-1:0] OUT_I,
    input wire logic [ddcr_pkg::SAMPLE_W-1:0] OUT_Q,
    input wire logic OUT_VALID,
    input wire logic OUT_READY
);
    // Strobes only count while the clock enable runs
    logic wr_ok;
    logic ctl_wr;
    assign wr_ok = CE && REG_WR;
    assign ctl_wr = wr_ok && REG_ADDR == ADDR_CTRL;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!NRST);

    property p_po_top;
        wr_ok && REG_ADDR == ADDR_PO_BYTE5 |=>
            OSCILLATOR_PHASE_OFFSET_WORD[47:40] == $past(REG_WDATA);
    endproperty
    a_po_top: assert property (p_po_top)
        else $error("phase offset top byte not written");
    property p_po_low;
        wr_ok && REG_ADDR == ADDR_PO_BYTE0 |=>
            OSCILLATOR_PHASE_OFFSET_WORD[7:0] == $past(REG_WDATA);
    endproperty
    a_po_low: assert property (p_po_low)
        else $error("phase offset low byte not written");
    property p_ten_rsv;
        CE && REG_RD && REG_ADDR == ADDR_TEST_EN |=> (REG_RDATA & 8'hFA) == 0;
    endproperty
    a_ten_rsv: assert property (p_ten_rsv)
        else $error("reserved test enable bits read nonzero");
    property p_mix;
        ctl_wr |=> MIXER_COMPLEX == $past(REG_WDATA[CTRL_MIX_BIT]);
    endproperty
    a_mix: assert property (p_mix)
        else $error("mixer select wrong");
    property p_if;
        ctl_wr |=> IF_MODE == $past(REG_WDATA[5:4]);
    endproperty
    a_if: assert property (p_if)
        else $error("IF mode wrong");
    property p_c2r;
        ctl_wr |=> COMPLEX_TO_REAL == $past(REG_WDATA[CTRL_C2R_BIT]);
    endproperty
    a_c2r: assert property (p_c2r)
        else $error("complex to real wrong");
    // Stage enables lag the control register by one enabled edge
    property p_hb12;
        ctl_wr && REG_WDATA[2:0] == 3'h0 ##1 CE |=> HALFBAND_STAGE_EN == 4'h3;
    endproperty
    a_hb12: assert property (p_hb12)
        else $error("stage enables wrong for code 000");
    property p_hb123;
        ctl_wr && REG_WDATA[2:0] == 3'h1 ##1 CE |=> HALFBAND_STAGE_EN == 4'h7;
    endproperty
    a_hb123: assert property (p_hb123)
        else $error("stage enables wrong for code 001");
    property p_hb1234;
        ctl_wr && REG_WDATA[2:0] == 3'h2 ##1 CE |=> HALFBAND_STAGE_EN == 4'hF;
    endproperty
    a_hb1234: assert property (p_hb1234)
        else $error("stage enables wrong for code 010");
    property p_hold;
        OUT_VALID && !OUT_READY |=>
            OUT_VALID && $stable(OUT_I) && $stable(OUT_Q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("output word changed while stalled");
endmodule

bind ddcr_top ddcr_top_checker u_chk (.CLOCK(CLOCK), .NRST(NRST), .CE(CE),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .OSCILLATOR_PHASE_OFFSET_WORD(OSCILLATOR_PHASE_OFFSET_WORD),
    .MIXER_COMPLEX(MIXER_COMPLEX), .IF_MODE(IF_MODE),
    .HALFBAND_STAGE_EN(HALFBAND_STAGE_EN), .COMPLEX_TO_REAL(COMPLEX_TO_REAL),
    .OUT_I(OUT_I), .OUT_Q(OUT_Q), .OUT_VALID(OUT_VALID),
    .OUT_READY(OUT_READY));
`default_nettype wire

// *** test/ddcr_top_tb_top.sv ***
// Self-checking bench for ddcr_top: registers, control decode and the
// decimating sample path under random stalls. Needs package and checker.
`timescale 1ns/1ps
`default_nettype none
module ddcr_top_tb_top;
    import ddcr_pkg::*;
    logic clock, nrst, ce, reg_wr, reg_rd, in_valid, out_ready;
    logic [11:0] reg_addr;
    logic [7:0] wdata, rdata, ctl, ten;
    logic [15:0] in_i, in_q, pat_a, pat_b, out_i, out_q;
    logic [47:0] po_word;
    logic [3:0] hb_en;
    logic [1:0] if_mode;
    logic mix, c2r, in_ready, out_valid;
    logic [31:0] exp_q [$];
    int n_errors, total_checks, k;
    logic [11:0] po_addr [6] = '{ADDR_PO_BYTE0, 12'h35E, 12'h35F,
        ADDR_PO_BYTE3, ADDR_PO_BYTE4, ADDR_PO_BYTE5};
    logic [7:0] cfg_ctl [4] = '{8'h00, 8'h4A, 8'h41, 8'h0B};
    logic [7:0] cfg_ten [4] = '{8'h00, 8'h05, 8'h04, 8'h00};

    ddcr_top DUT (.CLOCK(clock), .NRST(nrst), .CE(ce), .REG_ADDR(reg_addr),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(wdata),
        .REG_RDATA(rdata), .OSCILLATOR_PHASE_OFFSET_WORD(po_word),
        .MIXER_COMPLEX(mix), .IF_MODE(if_mode), .HALFBAND_STAGE_EN(hb_en),
        .COMPLEX_TO_REAL(c2r), .IN_I(in_i), .IN_Q(in_q),
        .IN_VALID(in_valid), .IN_READY(in_ready), .PATTERN_A(pat_a),
        .PATTERN_B(pat_b), .OUT_I(out_i), .OUT_Q(out_q),
        .OUT_VALID(out_valid), .OUT_READY(out_ready));

    // 50 ns period
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic tally_and_finish;
        if (n_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Strobes rise and fall on falling edges, one cycle wide
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        chk(rdata, e);
    endtask

    task automatic do_reset;
        @(negedge clock);
        nrst = 1'b0;
        repeat (2) @(negedge clock);
        nrst = 1'b1;
        k = 0;
        exp_q.delete();
    endtask

    function automatic logic [15:0] sat(input int v);
        if (v > 32767)
            return 16'h7FFF;
        if (v < -32768)
            return 16'h8000;
        return v[15:0];
    endfunction

    function automatic int dec_n(input logic [7:0] c);
        int n;
        n = (c[2:0] == 3'h1) ? 8 : (c[2:0] == 3'h2) ? 16 : 4;
        return c[3] ? n / 2 : n;
    endfunction

    function automatic logic [3:0] hb_of(input logic [2:0] c);
        return c == 3'h1 ? 4'h7 : c == 3'h2 ? 4'hF : 4'h3;
    endfunction

    // Full-scale corners turn up often so saturation gets exercised
    function automatic logic [15:0] pick;
        logic [2:0] r;
        r = 3'($urandom);
        return r == 0 ? 16'h8000 : r == 1 ? 16'h7FFF : 16'($urandom);
    endfunction

    // Expected output word for one accepted input sample
    task automatic accept;
        int vi, vq;
        logic [15:0] ri, rq;
        vi = $signed(in_i);
        vq = $signed(in_q);
        if (ctl[3])
        begin
            case (k % 4)
                1: vi = -vq;
                2: vi = -vi;
                3: vi = vq;
                default: ;
            endcase
            vq = 0;
        end
        ri = sat(vi);
        rq = sat(vq);
        if (ctl[6])
        begin
            ri = sat(2 * $signed(ri));
            rq = sat(2 * $signed(rq));
        end
        if (ten[0])
            ri = pat_a;
        if (ten[2])
            rq = pat_b;
        if (k % dec_n(ctl) == 0)
            exp_q.push_back({ri, rq});
        k++;
    endtask

    // Handshakes are judged on values that the next rising edge samples
    task automatic run(input int cyc, input int pv, input int pr);
        logic [31:0] e;
        for (int c = 0; c < cyc; c++)
        begin
            @(negedge clock);
            out_ready = ($urandom % 100) < pr;
            in_valid = ($urandom % 100) < pv;
            in_i = pick();
            in_q = pick();
            pat_a = 16'($urandom);
            pat_b = 16'($urandom);
            if (out_valid === 1'b1 && out_ready)
            begin
                e = exp_q.size() ? exp_q.pop_front() : 'x;
                chk({out_i, out_q}, e);
            end
            if (in_valid && in_ready === 1'b1)
                accept();
        end
    endtask

    // Guard against a hang anywhere in the sequence
    initial
    begin
        #2000000;
        n_errors++;
        tally_and_finish();
    end

    initial
    begin
        logic [7:0] v;
        logic [47:0] exp_po;
        {nrst, reg_wr, reg_rd, in_valid, out_ready} = 5'h00;
        {reg_addr, wdata, in_i, in_q, pat_a, pat_b} = '0;
        ce = 1'b1;
        exp_po = '0;
        void'($urandom(32'hA020C1D7));
        repeat (2) @(negedge clock);
        nrst = 1'b1;
        chk(hb_en, 4'h3);
        for (int j = 0; j < 6; j++)
            rdchk(po_addr[j], 8'h00);
        rdchk(ADDR_TEST_EN, 8'h00);
        rdchk(ADDR_CTRL, 8'h00);
        for (int j = 0; j < 6; j++)
        begin
            v = 8'($urandom);
            wr(po_addr[j], v);
            exp_po[j*8 +: 8] = v;
            rdchk(po_addr[j], v);
        end
        chk(po_word, exp_po);
        // Writes with the clock enable low must leave no trace
        ce = 1'b0;
        wr(ADDR_PO_BYTE5, ~exp_po[47:40]);
        ce = 1'b1;
        wr(12'h363, 8'hA5);
        chk(po_word, exp_po);
        rdchk(12'h363, 8'h00);
        wr(ADDR_TEST_EN, 8'hFF);
        rdchk(ADDR_TEST_EN, 8'h05);
        for (int j = 0; j < 8; j++)
        begin
            v = {j[0], j[1], j[1:0], j[2], j[2:0]};
            wr(ADDR_CTRL, v);
            @(negedge clock);
            chk({mix, if_mode, c2r}, {v[7], v[5:4], v[3]});
            chk(hb_en, hb_of(v[2:0]));
            rdchk(ADDR_CTRL, v);
        end
        // Sample path per configuration; the last one fills the buffer
        for (int j = 0; j < 4; j++)
        begin
            do_reset();
            ctl = cfg_ctl[j];
            ten = cfg_ten[j];
            wr(ADDR_CTRL, ctl);
            wr(ADDR_TEST_EN, ten);
            run(300, 80, 60);
            if (j == 3)
            begin
                run(60, 100, 0);
                chk(in_ready, 1'b0);
            end
            run(60, 0, 100);
            chk(exp_q.size(), 0);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
